// >>> core/ectc_mem.sv
// Trace record storage in flip-flops with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module ectc_mem (
  input wire logic ref_clk,
  input wire logic resetn,
  ectc_mem_if.mem port
);
  // Contents are not reset; the fill count in the controller says which entries are valid.
  ectc_pkg::ectc_rec_t store_r [ectc_pkg::DEPTH];
  ectc_pkg::ectc_rec_t rdata_r;

  always_ff @(posedge ref_clk) begin
    if (port.we) begin
      store_r[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= store_r[port.raddr];
    end
  end

  assign port.rdata = rdata_r;
endmodule
`default_nettype wire

// >>> core/ectc_mem_if.sv
// Connection between the capture control and the trace record storage.
`timescale 1ns/1ns
`default_nettype none
interface ectc_mem_if;
  logic we;
  logic [ectc_pkg::ADDR_W-1:0] waddr;
  ectc_pkg::ectc_rec_t wdata;
  logic [ectc_pkg::ADDR_W-1:0] raddr;
  ectc_pkg::ectc_rec_t rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> core/ectc_pkg.sv
// Constants, encodings and record layout of the emulator cycle trace capture.
package ectc_pkg;
  localparam int unsigned DEPTH = 131072;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned NUM_W = 18;
  localparam logic [NUM_W-1:0] DEPTH_NUM = 18'h2_0000;
  localparam logic [ADDR_W-1:0] PTR_LAST = 17'h1_ffff;
  localparam int unsigned AW = 24;
  localparam int unsigned OP_W = 40;
  localparam int unsigned TS_W = 38;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned TS_MHZ = 100;
  localparam logic [TS_W:0] TS_STEP = 39'(TS_MHZ / CLK_MHZ);
  localparam logic [TS_W-1:0] TS_RESET = 38'h00_0000_0000;

  typedef enum logic [2:0] {
    ECTC_IE_DECODE = 3'h0,
    ECTC_IE_HANDLER = 3'h1,
    ECTC_IE_INTERRUPTED = 3'h2,
    ECTC_IE_DISCARDED = 3'h3,
    ECTC_IE_PROCESSING = 3'h4,
    ECTC_IE_EXTRA = 3'h5
  } ectc_ievt_t;

  typedef enum logic [1:0] {
    ECTC_IRQ_NONE = 2'h0,
    ECTC_IRQ_RESET = 2'h1,
    ECTC_IRQ_TRAP = 2'h2,
    ECTC_IRQ_NUM = 2'h3
  } ectc_irq_t;

  typedef enum logic [2:0] {
    ECTC_AE_NONE = 3'h0,
    ECTC_AE_DATA = 3'h1,
    ECTC_AE_STACK = 3'h2,
    ECTC_AE_STALL = 3'h3,
    ECTC_AE_DMA = 3'h4
  } ectc_aevt_t;

  typedef struct packed {
    logic [AW-1:0] pc;
    ectc_ievt_t ievt;
    ectc_irq_t irq_kind;
    logic [4:0] irq_num;
    logic [OP_W-1:0] opcode;
    logic [AW-1:0] rd_addr;
    logic [23:0] rd_value;
    ectc_aevt_t rd_evt;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_value;
    ectc_aevt_t wr_evt;
    logic [TS_W-1:0] stamp;
    logic ts_restart;
    logic ts_discont;
    logic trace_start;
    logic trig_in;
    logic ana_in;
  } ectc_rec_t;
endpackage

// >>> core/ectc_top.sv
// Per-cycle trace capture of the emulated core into a circular record memory.
`timescale 1ns/1ns
`default_nettype none
module ectc_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic trace_arm,
  input wire logic trace_clear,
  input wire logic cpu_run,
  input wire logic cpu_stop,
  input wire logic cpu_sleep,
  input wire logic dec_start,
  input wire logic [23:0] dec_pc,
  input wire logic [39:0] dec_opcode,
  input wire logic irq_enter,
  input wire logic [1:0] irq_kind,
  input wire logic [4:0] irq_num,
  input wire logic instr_intr,
  input wire logic rd_req,
  input wire logic rd_stack,
  input wire logic rd_dma,
  input wire logic [23:0] rd_addr,
  input wire logic [1:0] rd_len,
  input wire logic rd_stall,
  input wire logic [31:0] rd_bus,
  input wire logic [7:0] dma_rd_bus,
  input wire logic wr_req,
  input wire logic wr_stack,
  input wire logic wr_dma,
  input wire logic wr_stall,
  input wire logic [23:0] wr_addr,
  input wire logic [7:0] wr_bus,
  input wire logic [7:0] dma_wr_bus,
  input wire logic trig_in,
  input wire logic ana_in,
  input wire logic host_rd_req,
  input wire logic [17:0] host_rd_num,
  output logic host_rd_valid,
  output ectc_pkg::ectc_rec_t host_rd_rec,
  output logic [17:0] rec_count,
  output logic buf_full,
  output logic tracing
);
  ectc_mem_if mbus ();

  ectc_mem u_mem (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .port(mbus.mem)
  );

  // Keeps only the width that the access length asks for.
  function automatic logic [23:0] len_mask(input logic [1:0] len, input logic [23:0] val);
    logic [23:0] m;
    m = 24'h00_00ff;
    if (len == 2'h2) begin
      m = 24'h00_ffff;
    end else if (len == 2'h3) begin
      m = 24'hff_ffff;
    end
    return val & m;
  endfunction

  // Capture state.
  logic [ectc_pkg::ADDR_W-1:0] wptr_r, wptr_nxt;
  logic [17:0] count_r, count_nxt;
  logic full_r, full_nxt;
  logic tracing_r, tracing_nxt;
  logic start_r, start_nxt;
  logic discont_r, discont_nxt;
  logic [ectc_pkg::TS_W-1:0] ts_r, ts_nxt;
  logic ts_wrap;
  logic capture;
  logic rec_we;
  ectc_pkg::ectc_rec_t rec;

  // Read pipeline state.
  logic rpend_r, rpend_nxt;
  logic [23:0] rpaddr_r, rpaddr_nxt;
  ectc_pkg::ectc_aevt_t rpsrc_r, rpsrc_nxt;
  logic [1:0] rplen_r, rplen_nxt;

  // Readout state.
  logic [1:0] hv_r, hv_nxt;
  logic [ectc_pkg::ADDR_W-1:0] raddr_r, raddr_nxt;
  ectc_pkg::ectc_rec_t hrec_r, hrec_nxt;
  logic hvalid_r, hvalid_nxt;

  // The counter advances two ticks per clock; a wrap shows as the carry out of the sum.
  always_comb begin
    logic [ectc_pkg::TS_W:0] sum;
    sum = {1'b0, ts_r} + ectc_pkg::TS_STEP;
    ts_nxt = sum[ectc_pkg::TS_W-1:0];
    ts_wrap = sum[ectc_pkg::TS_W];
  end

  assign capture = tracing_r && cpu_run;
  // A wrap while tracing is off still stores one record, unless the core sleeps.
  assign rec_we = capture || (ts_wrap && !cpu_sleep);

  always_comb begin
    rec = '0;
    rec.pc = dec_pc;
    rec.stamp = ts_r;
    rec.ts_restart = ts_wrap;
    rec.ts_discont = discont_r;
    rec.trace_start = start_r && capture;
    rec.trig_in = trig_in;
    rec.ana_in = ana_in;
    rec.irq_kind = ectc_pkg::ECTC_IRQ_NONE;
    if (!capture) begin
      rec.ievt = ectc_pkg::ECTC_IE_EXTRA;
    end else if (cpu_stop) begin
      rec.ievt = ectc_pkg::ECTC_IE_DISCARDED;
    end else if (irq_enter) begin
      rec.ievt = ectc_pkg::ECTC_IE_HANDLER;
      rec.irq_kind = ectc_pkg::ectc_irq_t'(irq_kind);
      if (irq_kind == ectc_pkg::ECTC_IRQ_NUM) begin
        rec.irq_num = irq_num;
      end
    end else if (instr_intr) begin
      rec.ievt = ectc_pkg::ECTC_IE_INTERRUPTED;
    end else if (dec_start) begin
      rec.ievt = ectc_pkg::ECTC_IE_DECODE;
      rec.opcode = dec_opcode;
    end else begin
      rec.ievt = ectc_pkg::ECTC_IE_PROCESSING;
    end
    if (capture) begin
      // A read request shows its address now unless a read is pending, and its value in the next cycle without a stall; a write shows both at once unless it stalls.
      if (rpend_r) begin
        rec.rd_addr = rpaddr_r;
        if (rd_stall) begin
          rec.rd_evt = ectc_pkg::ECTC_AE_STALL;
        end else begin
          rec.rd_evt = rpsrc_r;
          if (rpsrc_r == ectc_pkg::ECTC_AE_DMA) begin
            rec.rd_value = {16'h0000, dma_rd_bus};
          end else begin
            rec.rd_value = len_mask(rplen_r, rd_bus[23:0]);
          end
        end
      end else if (rd_req) begin
        rec.rd_addr = rd_addr;
      end
      if (wr_req) begin
        rec.wr_addr = wr_addr;
        if (wr_stall) begin
          rec.wr_evt = ectc_pkg::ECTC_AE_STALL;
        end else if (wr_dma) begin
          rec.wr_evt = ectc_pkg::ECTC_AE_DMA;
          rec.wr_value = dma_wr_bus;
        end else begin
          rec.wr_evt = wr_stack ? ectc_pkg::ECTC_AE_STACK : ectc_pkg::ECTC_AE_DATA;
          rec.wr_value = wr_bus;
        end
      end
    end
  end

  // Read request tracking; a stalled read keeps its slot until the data arrives.
  always_comb begin
    rpend_nxt = rpend_r;
    rpaddr_nxt = rpaddr_r;
    rpsrc_nxt = rpsrc_r;
    rplen_nxt = rplen_r;
    if (rpend_r && !rd_stall) begin
      rpend_nxt = 1'b0;
    end
    if (rd_req && !(rpend_r && rd_stall)) begin
      rpend_nxt = 1'b1;
      rpaddr_nxt = rd_addr;
      rplen_nxt = rd_len;
      if (rd_dma) begin
        rpsrc_nxt = ectc_pkg::ECTC_AE_DMA;
      end else if (rd_stack) begin
        rpsrc_nxt = ectc_pkg::ECTC_AE_STACK;
      end else begin
        rpsrc_nxt = ectc_pkg::ECTC_AE_DATA;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rpend_r <= 1'b0;
      rpaddr_r <= 24'h00_0000;
      rpsrc_r <= ectc_pkg::ECTC_AE_NONE;
      rplen_r <= 2'h1;
    end else begin
      rpend_r <= rpend_nxt;
      rpaddr_r <= rpaddr_nxt;
      rpsrc_r <= rpsrc_nxt;
      rplen_r <= rplen_nxt;
    end
  end

  // Buffer pointer, fill level and tracing mode.
  always_comb begin
    wptr_nxt = wptr_r;
    count_nxt = count_r;
    full_nxt = full_r;
    tracing_nxt = trace_arm;
    start_nxt = start_r;
    discont_nxt = discont_r;
    if (trace_arm && !tracing_r) begin
      start_nxt = 1'b1;
    end
    if (cpu_sleep) begin
      discont_nxt = 1'b1;
    end
    if (trace_clear) begin
      wptr_nxt = '0;
      count_nxt = 18'h0_0000;
      full_nxt = 1'b0;
    end else if (rec_we) begin
      wptr_nxt = wptr_r + 17'h0_0001;
      if (wptr_r == ectc_pkg::PTR_LAST) begin
        full_nxt = 1'b1;
      end
      if (count_r != ectc_pkg::DEPTH_NUM) begin
        count_nxt = count_r + 18'h0_0001;
      end
      if (!cpu_sleep) begin
        discont_nxt = 1'b0;
      end
      if (capture) begin
        start_nxt = 1'b0;
      end
    end
    // A stop ends the run; the next captured record after it opens a new trace.
    if (capture && cpu_stop) begin
      start_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wptr_r <= '0;
      count_r <= 18'h0_0000;
      full_r <= 1'b0;
      tracing_r <= 1'b0;
      start_r <= 1'b1;
      discont_r <= 1'b0;
      ts_r <= ectc_pkg::TS_RESET;
    end else begin
      wptr_r <= wptr_nxt;
      count_r <= count_nxt;
      full_r <= full_nxt;
      tracing_r <= tracing_nxt;
      start_r <= start_nxt;
      discont_r <= discont_nxt;
      ts_r <= ts_nxt;
    end
  end

  // Host readout: record number 1 is the oldest entry still held.
  always_comb begin
    logic [ectc_pkg::ADDR_W-1:0] base;
    base = full_r ? wptr_r : '0;
    hv_nxt = {hv_r[0], host_rd_req};
    raddr_nxt = raddr_r;
    if (host_rd_req) begin
      raddr_nxt = base + host_rd_num[ectc_pkg::ADDR_W-1:0] - 17'h0_0001;
    end
    hrec_nxt = hrec_r;
    hvalid_nxt = hv_r[1];
    if (hv_r[1]) begin
      hrec_nxt = mbus.rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hv_r <= 2'h0;
      raddr_r <= '0;
      hrec_r <= '0;
      hvalid_r <= 1'b0;
    end else begin
      hv_r <= hv_nxt;
      raddr_r <= raddr_nxt;
      hrec_r <= hrec_nxt;
      hvalid_r <= hvalid_nxt;
    end
  end

  assign mbus.we = rec_we && !trace_clear;
  assign mbus.waddr = wptr_r;
  assign mbus.wdata = rec;
  assign mbus.raddr = raddr_r;

  assign host_rd_valid = hvalid_r;
  assign host_rd_rec = hrec_r;
  assign rec_count = count_r;
  assign buf_full = full_r;
  assign tracing = tracing_r;
endmodule
`default_nettype wire

// >>> sim/ectc_checker.sv
// Port-level checks of counts, flags and readout timing of the cycle trace capture.
`timescale 1ns/1ns
`default_nettype none
module ectc_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic trace_arm,
  input wire logic trace_clear,
  input wire logic cpu_run,
  input wire logic host_rd_req,
  input wire logic host_rd_valid,
  input wire ectc_pkg::ectc_rec_t host_rd_rec,
  input wire logic [17:0] rec_count,
  input wire logic buf_full,
  input wire logic tracing
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_req; host_rd_req; endsequence
  sequence s_reply; ##3 host_rd_valid; endsequence
  property p_depth; rec_count <= ectc_pkg::DEPTH_NUM; endproperty
  property p_arm; 1'b1 |=> tracing == $past(trace_arm); endproperty
  property p_grow;
    tracing && cpu_run && !trace_clear && rec_count < ectc_pkg::DEPTH_NUM
      |=> rec_count == $past(rec_count) + 18'h0_0001;
  endproperty
  property p_clear; trace_clear |=> rec_count == 18'h0 && !buf_full; endproperty
  property p_full; buf_full |-> rec_count == ectc_pkg::DEPTH_NUM; endproperty
  property p_rd_lat; s_req |-> s_reply; endproperty
  property p_rd_cause; host_rd_valid |-> $past(host_rd_req, 3); endproperty
  property p_rec_hold; !host_rd_valid |-> $stable(host_rd_rec); endproperty
  a_depth: assert property (p_depth) else $error("record count above depth");
  a_arm: assert property (p_arm) else $error("tracing does not follow arm");
  a_grow: assert property (p_grow) else $error("captured cycle not counted");
  a_clear: assert property (p_clear) else $error("clear did not empty buffer");
  a_full: assert property (p_full) else $error("full flag without full count");
  a_rd_lat: assert property (p_rd_lat) else $error("readout reply late");
  a_rd_cause: assert property (p_rd_cause) else $error("readout reply unasked");
  a_rec_hold: assert property (p_rec_hold) else $error("readout record moved");
endmodule
bind ectc_top ectc_checker i_ectc_checker (.ref_clk, .resetn, .trace_arm, .trace_clear,
  .cpu_run, .host_rd_req, .host_rd_valid, .host_rd_rec, .rec_count, .buf_full, .tracing);
`default_nettype wire

// >>> sim/ectc_core_model.sv
// Behavioural emulated core: one bus operation per cycle chosen by op.
`timescale 1ns/1ns
`default_nettype none
module ectc_core_model (
  input wire logic ref_clk,
  input wire logic [3:0] op,
  output logic cpu_run,
  output logic cpu_stop,
  output logic dec_start,
  output logic [23:0] dec_pc,
  output logic [39:0] dec_opcode,
  output logic irq_enter,
  output logic [1:0] irq_kind,
  output logic [4:0] irq_num,
  output logic instr_intr,
  output logic rd_req,
  output logic rd_stack,
  output logic rd_dma,
  output logic [23:0] rd_addr,
  output logic [1:0] rd_len,
  output logic rd_stall,
  output logic [31:0] rd_bus,
  output logic [7:0] dma_rd_bus
);
  logic [1:0] len_r = 2'h3;
  wire logic rq = op == 4'h1 || op == 4'h7 || op == 4'h8;
  always_ff @(posedge ref_clk) if (rq) len_r <= rd_len;
  // Buses off their valid cycle show inverted data so stale values cannot pass.
  always_comb begin
    cpu_run = op != 4'h0;
    cpu_stop = op == 4'h6;
    dec_start = rq;
    dec_pc = {20'h0_0080, op};
    dec_opcode = {36'h5_5010_3010, op};
    irq_enter = op == 4'h4;
    irq_kind = irq_enter ? 2'h3 : 2'h0;
    irq_num = 5'h05;
    instr_intr = op == 4'h5;
    rd_req = rq;
    rd_stack = op == 4'h8;
    rd_dma = op == 4'h7;
    rd_addr = rq ? 24'h00_0104 : 24'hff_fefb;
    rd_len = op == 4'h8 ? 2'h2 : op == 4'h7 ? 2'h1 : rq ? 2'h3 : len_r;
    rd_stall = op == 4'h3;
    rd_bus = op == 4'h2 ? 32'h1234_5566 : 32'hedcb_aa99;
    dma_rd_bus = op == 4'h2 ? 8'h5a : 8'ha5;
  end
endmodule
`default_nettype wire

// >>> sim/ectc_top_tb.sv
// Self-checking bench of the cycle trace capture.
`timescale 1ns/1ns
`default_nettype none
module ectc_top_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic trace_arm = 1'b0;
  logic trace_clear = 1'b0;
  logic host_rd_req = 1'b0;
  logic [17:0] host_rd_num = 18'h0_0001;
  logic [3:0] op = 4'h0;
  logic cpu_run, cpu_stop, dec_start, irq_enter, instr_intr, rd_req, rd_stack, rd_dma, rd_stall;
  logic [23:0] dec_pc, rd_addr;
  logic [39:0] dec_opcode;
  logic [1:0] irq_kind, rd_len;
  logic [4:0] irq_num;
  logic [31:0] rd_bus;
  logic [7:0] dma_rd_bus;
  logic host_rd_valid, buf_full, tracing;
  logic [17:0] rec_count;
  ectc_pkg::ectc_rec_t host_rd_rec;
  int num_errors = 0;
  int comparisons = 0;
  // Rows, one nibble each: core op, expected instruction event, expected read event.
  localparam logic [47:0] OPS = 48'h1213_2827_2456;
  localparam logic [47:0] IEV = 48'h0404_4040_4123;
  localparam logic [47:0] AEV = 48'h0103_1020_4000;
  ectc_core_model i_ectc_core_model (.ref_clk, .op, .cpu_run, .cpu_stop, .dec_start, .dec_pc,
    .dec_opcode, .irq_enter, .irq_kind, .irq_num, .instr_intr, .rd_req, .rd_stack, .rd_dma,
    .rd_addr, .rd_len, .rd_stall, .rd_bus, .dma_rd_bus);
  ectc_top i_ectc_top (.ref_clk, .resetn, .trace_arm, .trace_clear, .cpu_run, .cpu_stop,
    .cpu_sleep(1'b0), .dec_start, .dec_pc, .dec_opcode, .irq_enter, .irq_kind, .irq_num,
    .instr_intr, .rd_req, .rd_stack, .rd_dma, .rd_addr, .rd_len, .rd_stall, .rd_bus,
    .dma_rd_bus, .wr_req(rd_req), .wr_stack(rd_stack), .wr_dma(rd_dma), .wr_stall(1'b0),
    .wr_addr(dec_pc), .wr_bus(rd_bus[7:0]), .dma_wr_bus(8'h00), .trig_in(1'b0), .ana_in(1'b0),
    .host_rd_req, .host_rd_num, .host_rd_valid, .host_rd_rec, .rec_count, .buf_full, .tracing);
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    wrap_up();
  end
  initial begin
    logic [3:0] o;
    logic [2:0] ev, ae;
    logic [23:0] v;
    repeat (10) @(negedge ref_clk);
    chk("count", 18'h0, rec_count);
    chk("full", 1'b0, buf_full);
    chk("tracing", 1'b0, tracing);
    resetn = 1'b1;
    trace_arm = 1'b1;
    @(negedge ref_clk);
    chk("tracing", 1'b1, tracing);
    for (int i = 0; i < 12; i++) begin
      op = OPS[44-4*i +: 4];
      @(negedge ref_clk);
    end
    op = 4'h0;
    @(negedge ref_clk);
    chk("count", 18'h0_000c, rec_count);
    // The arm is dropped a cycle early, since the registered flag lags it by one edge.
    trace_arm = 1'b0;
    @(negedge ref_clk);
    op = 4'h1;
    repeat (2) @(negedge ref_clk);
    op = 4'h0;
    @(negedge ref_clk);
    chk("count", 18'h0_000c, rec_count);
    for (int i = 0; i < 12; i++) begin
      o = OPS[44-4*i +: 4];
      ev = IEV[44-4*i +: 3];
      ae = AEV[44-4*i +: 3];
      v = ae == 3'h1 ? 24'h34_5566 : ae == 3'h2 ? 24'h00_5566 : ae == 3'h4 ? 24'h00_005a : 24'h0;
      host_rd_num = 18'(i + 1);
      host_rd_req = 1'b1;
      @(negedge ref_clk);
      host_rd_req = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk("valid", 1'b1, host_rd_valid);
      chk("pc", {20'h0_0080, o}, host_rd_rec.pc);
      chk("ievt", ev, host_rd_rec.ievt);
      chk("opcode", ev == 3'h0 ? {36'h5_5010_3010, o} : 40'h0, host_rd_rec.opcode);
      chk("waddr", ev == 3'h0 ? {20'h0_0080, o} : 24'h0, host_rd_rec.wr_addr);
      chk("start", i == 0, host_rd_rec.trace_start);
      if (ev == 3'h0 || ae != 3'h0) chk("raddr", 24'h00_0104, host_rd_rec.rd_addr);
      chk("revt", ae, host_rd_rec.rd_evt);
      chk("rvalue", v, host_rd_rec.rd_value);
      if (ev == 3'h1) chk("irq", 7'h65, {host_rd_rec.irq_kind, host_rd_rec.irq_num});
    end
    trace_clear = 1'b1;
    @(negedge ref_clk);
    trace_clear = 1'b0;
    @(negedge ref_clk);
    chk("count", 18'h0, rec_count);
    trace_arm = 1'b1;
    op = 4'h1;
    repeat (2) @(negedge ref_clk);
    chk("count", 18'h0_0001, rec_count);
    // Reset spans two edges so the readout record is already cleared when checks resume.
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("count", 18'h0, rec_count);
    chk("tracing", 1'b0, tracing);
    chk("valid", 1'b0, host_rd_valid);
    op = 4'h0;
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("tracing", 1'b1, tracing);
    wrap_up();
  end
endmodule
`default_nettype wire
